// ===== hw/drc_pkg.sv
// Constants and types for the reset and restart configuration bank
// Functional notes
// RULE1: Memory select 0 reverts, 1 keeps frequency
// RULE2: Mode 0: full reset, counter clear on rise
// RULE3: Mode 1: full reset, counter clear on fall
// RULE4: Mode 2: only with trip, cancel and clear
// RULE5: Mode 3: only with trip, cancel, keep counter
// RULE6: Restart 0 from zero, 1 after matching
// RULE7: Restart 2 uses active frequency matching
// RULE8: 16-bit registers; out-of-range writes are rejected
package drc_pkg;
	// Holding register addresses
	localparam logic [15:0] ADDR_THERM = 16'h1459;
	localparam logic [15:0] ADDR_DEBUG = 16'h145F;
	localparam logic [15:0] ADDR_UPDN = 16'h1469;
	localparam logic [15:0] ADDR_RSTMODE = 16'h146A;
	localparam logic [15:0] ADDR_RESTART = 16'h146B;
	localparam logic [15:0] ADDR_PGAIN = 16'h146D;
	localparam logic [15:0] ADDR_VGAIN = 16'h146E;
	localparam logic [15:0] ADDR_IGAIN = 16'h146F;
	// Legal ranges
	localparam logic [15:0] THERM_MAX = 16'h2710;
	localparam logic [15:0] DEBUG_MAX = 16'h0001;
	localparam logic [15:0] UPDN_MAX = 16'h0001;
	localparam logic [15:0] RSTMODE_MAX = 16'h0003;
	localparam logic [15:0] RESTART_MAX = 16'h0002;
	localparam logic [15:0] GAIN_MIN = 16'h0032;
	localparam logic [15:0] GAIN_MAX = 16'h00C8;
	// Values after reset
	localparam logic [15:0] THERM_RST = 16'h0000;
	localparam logic [15:0] UPDN_RST = 16'h0000;
	localparam logic [15:0] RSTMODE_RST = 16'h0000;
	localparam logic [15:0] RESTART_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST = 16'h0064;
	// Reset-input behaviour codes
	localparam logic [1:0] RM_CLR_ON = 2'h0;
	localparam logic [1:0] RM_CLR_OFF = 2'h1;
	localparam logic [1:0] RM_TRIP_CLR = 2'h2;
	localparam logic [1:0] RM_TRIP_KEEP = 2'h3;
	// Restart strategies
	localparam logic [1:0] RS_ZERO = 2'h0;
	localparam logic [1:0] RS_MATCH = 2'h1;
	localparam logic [1:0] RS_ACTIVE = 2'h2;
	// Restart sequencer states, one-hot
	typedef enum logic [3:0] {
		DRC_IDLE = 4'b0001,
		DRC_HOLD = 4'b0010,
		DRC_MATCH = 4'b0100,
		DRC_RUN = 4'b1000
	} drc_state_e;
endpackage

// ===== hw/drc_bus_if.sv
// Configuration interface between the bank and the reset sequencer
`timescale 1ns/1ps
`default_nettype none
interface drc_bus_if;
	logic updn_keep; // Keep last frequency
	logic [1:0] reset_mode; // Reset-input behaviour
	logic [1:0] restart_mode; // Restart strategy
	modport bank (output updn_keep, output reset_mode, output restart_mode);
	modport seq (input updn_keep, input reset_mode, input restart_mode);
endinterface
`default_nettype wire

// ===== hw/drc_regbank.sv
// Holding register storage with range checks
`timescale 1ns/1ps
`default_nettype none
module drc_regbank (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic debug_display,
	output logic [15:0] rdata_q,
	output logic ack_q,
	output logic err_q,
	output logic [15:0] pgain_q,
	output logic [15:0] vgain_q,
	output logic [15:0] igain_q,
	output logic [15:0] therm_q,
	drc_bus_if.bank cfg
);
	logic [15:0] updn_q;
	logic [15:0] rstmode_q;
	logic [15:0] restart_q;
	// Range test shared by every writable register
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction
	// Per-register write legality
	wire logic ok_therm = in_range(wdata, 16'h0000, drc_pkg::THERM_MAX);
	wire logic ok_updn = in_range(wdata, 16'h0000, drc_pkg::UPDN_MAX);
	wire logic ok_rst = in_range(wdata, 16'h0000, drc_pkg::RSTMODE_MAX);
	wire logic ok_restart = in_range(wdata, 16'h0000, drc_pkg::RESTART_MAX);
	wire logic ok_gain = in_range(wdata, drc_pkg::GAIN_MIN, drc_pkg::GAIN_MAX);
	wire logic hit_therm = addr == drc_pkg::ADDR_THERM;
	wire logic hit_debug = addr == drc_pkg::ADDR_DEBUG;
	wire logic hit_updn = addr == drc_pkg::ADDR_UPDN;
	wire logic hit_rst = addr == drc_pkg::ADDR_RSTMODE;
	wire logic hit_restart = addr == drc_pkg::ADDR_RESTART;
	wire logic hit_pg = addr == drc_pkg::ADDR_PGAIN;
	wire logic hit_vg = addr == drc_pkg::ADDR_VGAIN;
	wire logic hit_ig = addr == drc_pkg::ADDR_IGAIN;
	// RULE8: legal write check
	wire logic wr_ok = (hit_therm & ok_therm) | (hit_updn & ok_updn) | (hit_rst & ok_rst)
		| (hit_restart & ok_restart) | ((hit_pg | hit_vg | hit_ig) & ok_gain);
	wire logic rd_hit = hit_therm | hit_debug | hit_updn | hit_rst | hit_restart | hit_pg | hit_vg | hit_ig;
	// Read mux; debug flag reflects the live input
	wire logic [15:0] rd_mux = hit_therm ? therm_q :
		hit_debug ? {15'h0000, debug_display} :
		hit_updn ? updn_q :
		hit_rst ? rstmode_q :
		hit_restart ? restart_q :
		hit_pg ? pgain_q :
		hit_vg ? vgain_q :
		hit_ig ? igain_q : 16'h0000;
	assign cfg.updn_keep = updn_q[0];
	assign cfg.reset_mode = rstmode_q[1:0];
	assign cfg.restart_mode = restart_q[1:0];
	// Storage; rejected writes leave the old value
	always_ff @(posedge clk) begin
		if (reset) begin
			therm_q <= drc_pkg::THERM_RST;
			updn_q <= drc_pkg::UPDN_RST;
			rstmode_q <= drc_pkg::RSTMODE_RST;
			restart_q <= drc_pkg::RESTART_RST;
			pgain_q <= drc_pkg::GAIN_RST;
			vgain_q <= drc_pkg::GAIN_RST;
			igain_q <= drc_pkg::GAIN_RST;
		end else if (wr_en && wr_ok) begin
			if (hit_therm) therm_q <= wdata;
			if (hit_updn) updn_q <= wdata;
			if (hit_rst) rstmode_q <= wdata;
			if (hit_restart) restart_q <= wdata;
			if (hit_pg) pgain_q <= wdata;
			if (hit_vg) vgain_q <= wdata;
			if (hit_ig) igain_q <= wdata;
		end
	end
	// One-cycle answer to each access
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= 16'h0000;
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ack_q <= wr_en | rd_en;
			err_q <= (wr_en & ~wr_ok) | (rd_en & ~wr_en & ~rd_hit);
			rdata_q <= (rd_en && !wr_en) ? rd_mux : 16'h0000;
		end
	end
endmodule // drc_regbank
`default_nettype wire

// ===== hw/drc_top.sv
// Drive reset, restart and frequency-memory configuration top
`timescale 1ns/1ps
`default_nettype none
module drc_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata,
	output logic ack,
	output logic err,
	input wire logic debug_display,
	input wire logic reset_input,
	input wire logic trip_active,
	input wire logic freq_step_event,
	input wire logic [15:0] freq_step_value,
	input wire logic [15:0] default_frequency_setting,
	input wire logic power_up,
	input wire logic match_done,
	output logic trip_cancel,
	output logic output_stop,
	output logic cpu_reset,
	output logic position_clear,
	output logic [15:0] frequency_target,
	output logic restart_zero,
	output logic restart_match,
	output logic restart_active,
	output logic [15:0] pgain,
	output logic [15:0] vgain,
	output logic [15:0] igain,
	output logic [15:0] therm_tuning
);
	drc_bus_if cfg ();
	logic rin_s1_q, rin_s2_q, rin_prev_q;
	logic trip_s1_q, trip_s2_q;
	logic dbg_s1_q, dbg_s2_q;
	logic pwr_s1_q, pwr_s2_q;
	logic md_s1_q, md_s2_q;
	logic trip_cancel_q, output_stop_q, cpu_reset_q, position_clear_q;
	logic r_zero_q, r_match_q, r_active_q;
	logic [15:0] freq_q;
	drc_pkg::drc_state_e state_q, state_d;
	// Register bank instance
	drc_regbank u_bank (
		.clk(clk),
		.reset(reset),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wdata(wdata),
		.debug_display(dbg_s2_q),
		.rdata_q(rdata),
		.ack_q(ack),
		.err_q(err),
		.pgain_q(pgain),
		.vgain_q(vgain),
		.igain_q(igain),
		.therm_q(therm_tuning),
		.cfg(cfg.bank)
	);
	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (reset) begin
			{rin_s1_q, rin_s2_q, trip_s1_q, trip_s2_q} <= 4'h0;
			{dbg_s1_q, dbg_s2_q, pwr_s1_q, pwr_s2_q, md_s1_q, md_s2_q} <= 6'h00;
		end else begin
			rin_s1_q <= reset_input;
			rin_s2_q <= rin_s1_q;
			trip_s1_q <= trip_active;
			trip_s2_q <= trip_s1_q;
			dbg_s1_q <= debug_display;
			dbg_s2_q <= dbg_s1_q;
			pwr_s1_q <= power_up;
			pwr_s2_q <= pwr_s1_q;
			md_s1_q <= match_done;
			md_s2_q <= md_s1_q;
		end
	end
	// Edge history of the synchronised reset input
	always_ff @(posedge clk) begin
		if (reset) rin_prev_q <= 1'b0;
		else rin_prev_q <= rin_s2_q;
	end
	wire logic rin_rise = rin_s2_q & ~rin_prev_q;
	wire logic rin_fall = ~rin_s2_q & rin_prev_q;
	wire logic mode_full = (cfg.reset_mode == drc_pkg::RM_CLR_ON) | (cfg.reset_mode == drc_pkg::RM_CLR_OFF);
	// RULE2: full reset on rising edge, mode 0 clears counter too
	// RULE3: mode 1 defers the counter clear to the falling edge
	wire logic full_act = rin_rise & mode_full;
	// RULE4: mode 2 acts only while tripped
	// RULE5: mode 3 cancels trip, counter untouched
	wire logic trip_act = rin_rise & trip_s2_q & ~mode_full;
	wire logic pos_clr = (rin_rise & (cfg.reset_mode == drc_pkg::RM_CLR_ON))
		| (rin_fall & (cfg.reset_mode == drc_pkg::RM_CLR_OFF))
		| (trip_act & (cfg.reset_mode == drc_pkg::RM_TRIP_CLR));
	wire logic any_act = full_act | trip_act;
	// One-cycle action pulses
	always_ff @(posedge clk) begin
		if (reset) begin
			trip_cancel_q <= 1'b0;
			output_stop_q <= 1'b0;
			cpu_reset_q <= 1'b0;
			position_clear_q <= 1'b0;
		end else begin
			trip_cancel_q <= any_act;
			output_stop_q <= full_act;
			cpu_reset_q <= full_act;
			position_clear_q <= pos_clr;
		end
	end
	assign trip_cancel = trip_cancel_q;
	assign output_stop = output_stop_q;
	assign cpu_reset = cpu_reset_q;
	assign position_clear = position_clear_q;
	// Frequency memory; step inputs come from same-clock logic
	always_ff @(posedge clk) begin
		if (reset) freq_q <= 16'h0000;
		else if (freq_step_event) freq_q <= freq_step_value;
		// RULE1: discard last frequency when memory off
		else if ((pwr_s2_q | any_act) && !cfg.updn_keep) freq_q <= default_frequency_setting;
	end
	assign frequency_target = freq_q;
	// Restart sequencer: holds while reset input asserted
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			drc_pkg::DRC_IDLE: begin
				if (any_act) state_d = drc_pkg::DRC_HOLD;
			end
			drc_pkg::DRC_HOLD: begin
				// RULE6: zero start goes straight to run
				if (!rin_s2_q) state_d = (cfg.restart_mode == drc_pkg::RS_ZERO) ? drc_pkg::DRC_RUN : drc_pkg::DRC_MATCH;
			end
			drc_pkg::DRC_MATCH: begin
				// RULE7: matching modes wait for match done
				if (md_s2_q) state_d = drc_pkg::DRC_RUN;
			end
			drc_pkg::DRC_RUN: begin
				state_d = drc_pkg::DRC_IDLE;
			end
			default: state_d = drc_pkg::DRC_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) state_q <= drc_pkg::DRC_IDLE;
		else state_q <= state_d;
	end
	// Restart strategy strobes: matching kinds held during matching, zero start on the run pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			r_zero_q <= 1'b0;
			r_match_q <= 1'b0;
			r_active_q <= 1'b0;
		end else begin
			r_zero_q <= (state_d == drc_pkg::DRC_RUN) && (cfg.restart_mode == drc_pkg::RS_ZERO);
			r_match_q <= (state_d == drc_pkg::DRC_MATCH) && (cfg.restart_mode == drc_pkg::RS_MATCH);
			r_active_q <= (state_d == drc_pkg::DRC_MATCH) && (cfg.restart_mode == drc_pkg::RS_ACTIVE);
		end
	end
	assign restart_zero = r_zero_q;
	assign restart_match = r_match_q;
	assign restart_active = r_active_q;
endmodule // drc_top
`default_nettype wire

// ===== tb/drc_monitor.sv
// Port checker for the reset and restart configuration bank
`timescale 1ns/1ps
`default_nettype none
module drc_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] addr,
	input wire logic [15:0] rdata,
	input wire logic ack,
	input wire logic err,
	input wire logic restart_match,
	input wire logic restart_active,
	input wire logic [15:0] pgain,
	input wire logic [15:0] therm_tuning
);
	// One clock domain, so clocking and disable are shared
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_ack_follows_req: assert property ((wr_en || rd_en) |=> ack)
		else $error("ack missing after request");
	a_no_stray_ack: assert property (ack |-> $past(wr_en) || $past(rd_en))
		else $error("ack without request");
	a_err_with_ack: assert property (err |-> ack)
		else $error("err outside ack");
	a_idle_rdata_zero: assert property (!ack |-> rdata == 16'h0000)
		else $error("rdata not zero while idle");
	a_unmapped_read_err: assert property (rd_en && !wr_en && addr == 16'h1460 |=> err)
		else $error("unmapped read not refused");
	a_gain_in_range: assert property (pgain >= 16'h0032 && pgain <= 16'h00C8)
		else $error("gain left its range");
	a_therm_in_range: assert property (therm_tuning <= 16'h2710)
		else $error("tuning left its range");
	a_one_restart_kind: assert property (!(restart_match && restart_active))
		else $error("two restart kinds at once");
endmodule // drc_monitor
`default_nettype wire

// ===== tb/drc_master_model.sv
// Network master issuing holding-register reads and writes
`timescale 1ns/1ps
`default_nettype none
module drc_master_model (
	input wire logic clk,
	output logic wr_en,
	output logic rd_en,
	output logic [15:0] addr,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ack,
	input wire logic err
);
	// Bus idle from time zero
	initial {wr_en, rd_en, addr, wdata} = 34'h0;
	// Strobe stands one cycle; a missing ack turns the error flag unknown
	task automatic xfer(input logic wr, input logic [15:0] a, d, output logic [15:0] q, output logic e);
		@(posedge clk);
		#1 {wr_en, rd_en, addr, wdata} = {wr, !wr, a, d};
		@(posedge clk);
		#1 q = rdata;
		e = ack ? err : 1'bx;
		{wr_en, rd_en} = 2'b00;
	endtask
endmodule // drc_master_model
`default_nettype wire

// ===== tb/test_drc_top.sv
// Randomised self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_drc_top;
	logic clk, reset, wr_en, rd_en, ack, err, e, debug_display, reset_input, trip_active, step, match_done, pwr;
	logic trip_cancel, output_stop, cpu_reset, position_clear, restart_zero, restart_match, restart_active;
	logic [15:0] addr, wdata, rdata, fv, dflt, frequency_target, pgain, vgain, igain, therm_tuning, q, v;
	logic [1:0] md, rs;
	logic act;
	logic [15:0] regs [8];
	logic [15:0] adr [9] = '{16'h1459, 16'h145F, 16'h1469, 16'h146A, 16'h146B, 16'h146D, 16'h146E, 16'h146F, 16'h1460};
	int ci [8] = '{0, 0, 5, 5, 3, 3, 4, 4};
	logic [15:0] cv [8] = '{16'h2710, 16'h2711, 16'h0031, 16'h00C8, 16'h0003, 16'h0004, 16'h0002, 16'h0003};
	int i, n, seed, error_cnt, cmp_count;
	int cnt [7];
	wire [6:0] seen = {restart_active, restart_match, restart_zero, position_clear, cpu_reset, output_stop, trip_cancel};
	drc_master_model m (.clk, .wr_en, .rd_en, .addr, .wdata, .rdata, .ack, .err);
	drc_top dut (.clk, .reset, .wr_en, .rd_en, .addr, .wdata, .rdata, .ack, .err, .debug_display, .reset_input,
		.trip_active, .freq_step_event(step), .freq_step_value(fv), .default_frequency_setting(dflt),
		.power_up(pwr), .match_done, .trip_cancel, .output_stop, .cpu_reset, .position_clear, .frequency_target,
		.restart_zero, .restart_match, .restart_active, .pgain, .vgain, .igain, .therm_tuning);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cycles each action output was seen high
	always @(posedge clk) foreach (cnt[k]) cnt[k] += seen[k];
	// Range per register slot; read-only and unmapped refuse every write
	function automatic logic ok(input int k, input logic [15:0] d);
		case (k)
			0: ok = d <= 16'h2710;
			2: ok = d <= 16'h0001;
			3: ok = d <= 16'h0003;
			4: ok = d <= 16'h0002;
			5, 6, 7: ok = d >= 16'h0032 && d <= 16'h00C8;
			default: ok = 1'b0;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [15:0] ex, got);
		cmp_count++;
		if (got !== ex) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	initial begin
		#100000 error_cnt++;
		stop_test();
	end
	initial begin
		seed = 32'hcfcfd923;
		{reset, debug_display, reset_input, trip_active, step, match_done, pwr} = 7'h40;
		{fv, dflt} = {16'h0000, 16'h1234};
		regs = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0064};
		wait_cyc(10);
		reset = 1'b0;
		for (i = 0; i < 9; i++) begin
			m.xfer(1'b0, adr[i], 16'h0000, q, e);
			chk("reset value", i < 8 ? regs[i] : 16'h0000, q);
			chk("read refusal", {15'h0, i == 8}, {15'h0, e});
		end
		// Boundary values first, then random slots and values
		for (n = 0; n < 70; n++) begin
			i = n < 8 ? ci[n] : {$random(seed)} % 9;
			v = n < 8 ? cv[n] : n[0] ? 16'($random(seed)) : 16'({$random(seed)} % 208);
			m.xfer(1'b1, adr[i], v, q, e);
			chk("write refusal", {15'h0, !ok(i, v)}, {15'h0, e});
			if (ok(i, v)) regs[i] = v;
			m.xfer(1'b0, adr[i], 16'h0000, q, e);
			chk("readback", i < 8 ? regs[i] : 16'h0000, q);
			// Stored values also drive the gain and tuning outputs
			chk("tuning output", regs[0], therm_tuning);
			chk("pulse gain output", regs[5], pgain);
			chk("voltage gain output", regs[6], vgain);
			chk("current gain output", regs[7], igain);
		end
		debug_display = 1'b1;
		wait_cyc(3);
		m.xfer(1'b0, 16'h145F, 16'h0000, q, e);
		chk("debug flag", 16'h0001, q);
		// Every reset mode with and without a trip; restart and memory follow
		for (n = 0; n < 8; n++) begin
			md = n[2:1];
			rs = md == 2'h3 ? 2'h0 : md;
			act = md < 2 || n[0];
			m.xfer(1'b1, 16'h146A, {14'h0, md}, q, e);
			m.xfer(1'b1, 16'h146B, {14'h0, rs}, q, e);
			m.xfer(1'b1, 16'h1469, {15'h0, md[0]}, q, e);
			{step, fv, trip_active} = {1'b1, 16'($random(seed)), n[0]};
			wait_cyc(1);
			step = 1'b0;
			wait_cyc(3);
			cnt = '{default: 0};
			reset_input = 1'b1;
			wait_cyc(10);
			chk("clear before fall", {15'h0, !md[0] && act}, {15'h0, cnt[3] != 0});
			reset_input = 1'b0;
			wait_cyc(10);
			match_done = 1'b1;
			wait_cyc(6);
			{match_done, trip_active} = 2'b00;
			wait_cyc(4);
			chk("actions", {9'h0, act && rs == 2, act && rs == 1, act && rs == 0, act && md != 3, md < 2, md < 2, act},
				{9'h0, cnt[6] != 0, cnt[5] != 0, cnt[4] == 1, cnt[3] == 1, cnt[2] == 1, cnt[1] == 1, cnt[0] == 1});
			chk("restart idle", 16'h0000, {14'h0, restart_match, restart_active});
			chk("frequency", act && !md[0] ? dflt : fv, frequency_target);
			// Power-up reloads the default only while the memory is off
			{pwr, dflt} = {1'b1, 16'($random(seed))};
			wait_cyc(4);
			pwr = 1'b0;
			chk("power-up frequency", md[0] ? fv : dflt, frequency_target);
			wait_cyc(3);
		end
		// Second reset in mid-run brings every writable register back
		reset = 1'b1;
		wait_cyc(10);
		reset = 1'b0;
		for (i = 0; i < 8; i++) begin
			m.xfer(1'b0, adr[i], 16'h0000, q, e);
			chk("value after reset", i == 1 ? 16'h0001 : i > 4 ? 16'h0064 : 16'h0000, q);
		end
		chk("frequency after reset", 16'h0000, frequency_target);
		stop_test();
	end
endmodule // test_drc_top
bind drc_top drc_monitor mon (.clk, .reset, .wr_en, .rd_en, .addr, .rdata, .ack, .err, .restart_match,
	.restart_active, .pgain, .therm_tuning);
`default_nettype wire
